// ===== cpr_pkg.sv
`default_nettype none
package cpr_pkg;
  // apb register byte offsets
  localparam logic [11:0] CPR_OFS_PC = 12'h000;
  localparam logic [11:0] CPR_OFS_PSW = 12'h004;
  localparam logic [11:0] CPR_OFS_SP = 12'h008;
  localparam logic [11:0] CPR_OFS_STAT = 12'h00C;
  // status word bit positions
  localparam int CPR_B_INTEN = 7;
  localparam int CPR_B_Z = 6;
  localparam int CPR_B_BANK1 = 5;
  localparam int CPR_B_HCARRY = 4;
  localparam int CPR_B_BANK0 = 3;
  localparam int CPR_B_INSRV = 1;
  localparam int CPR_B_CARRY = 0;
  localparam logic [7:0] CPR_PSW_RST = 8'h02;
  localparam logic [7:0] CPR_PSW_WMASK = 8'hFB;
  // reset vector words
  localparam logic [15:0] CPR_VEC_LO = 16'h0000;
  localparam logic [15:0] CPR_VEC_HI = 16'h0001;
  // memory map
  localparam logic [15:0] CPR_GPR_BASE = 16'hFEE0;
  localparam logic [15:0] CPR_GPR_TOP = 16'hFEFF;
  localparam logic [15:0] CPR_SFR_BASE = 16'hFF00;
  localparam logic [15:0] CPR_HSRAM_LO = 16'hFC00;
  localparam logic [15:0] CPR_HSRAM_TOP = 16'hFEFF;
  localparam logic [15:0] CPR_DDU_TOP = 16'h0003;
  localparam int CPR_BANK_REGS = 8;
  localparam int CPR_BANKS = 4;
  // access widths
  localparam logic [1:0] CPR_W_BIT = 2'h0;
  localparam logic [1:0] CPR_W_BYTE = 2'h1;
  localparam logic [1:0] CPR_W_WORD = 2'h2;
  typedef enum logic [1:0] {
    CPR_FETCH_LO,
    CPR_FETCH_HI,
    CPR_RUN
  } cpr_vec_t;
endpackage
`default_nettype wire

// ===== cpr_regs.sv
// What this block does
// - program counter holds next fetch address, advances by instruction length
// - branch loads program counter from immediate or register value
// - after reset program counter loads from vector bytes at 0000H and 0001H
// - vector low byte from even address, high byte from next odd address
// - status word pushed on interrupt or push, restored on returns and pop
// - status word resets to 02H
// - enable flag low refuses maskable requests; high defers to priority gating
// - mask-all or acknowledge clears enable flag; unmask-all sets it
// - zero flag set on zero result, cleared otherwise
// - two-bit bank select field written by bank-switch instruction
// - aux carry set on carry or borrow at bit 3, else cleared
// - in-service flag low blocks low priority requests; enable still gates
// - carry flag holds add/subtract overflow, rotate shift-out, bit accumulator
// - sixteen-bit stack pointer; stack access outside internal high-speed ram sets a sticky error
// - stack pointer decrements before each write, increments after each read
// - general registers at FEE0H-FEFFH, four banks of eight bytes
// - bank registers used singly or as four sixteen-bit pairs
// - special registers at FF00H-FFFFH plus display unit offsets 00H-03H
// - special register access widths as permitted; word accesses on even address
`timescale 1ns/100ps
`default_nettype none
module cpr_regs
  import cpr_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // reset vector fetch
  output logic VEC_REQ,
  output logic [15:0] VEC_ADDR,
  input wire logic VEC_ACK,
  input wire logic [7:0] VEC_DATA,
  output logic CORE_RUN,
  // sequencing
  input wire logic PC_ADV,
  input wire logic [1:0] PC_LEN,
  input wire logic BRANCH,
  input wire logic [15:0] BR_TARGET,
  output logic [15:0] PC_OUT,
  // flags
  input wire logic ALU_UPD,
  input wire logic [7:0] ALU_RES,
  input wire logic ALU_HCARRY,
  input wire logic ALU_CARRY,
  input wire logic CARRY_WE,
  input wire logic CARRY_IN,
  input wire logic MASK_ALL,
  input wire logic UNMASK_ALL,
  input wire logic BANK_SW,
  input wire logic [1:0] BANK_IN,
  input wire logic INSRV_WE,
  input wire logic INSRV_IN,
  output logic [7:0] PSW_OUT,
  // interrupt acceptance
  input wire logic INT_REQ,
  input wire logic INT_LOW_PRI,
  input wire logic INT_MASKED,
  input wire logic INT_ACK,
  output logic INT_OK,
  // stack
  input wire logic STK_PUSH,
  input wire logic [7:0] STK_DIN,
  input wire logic PUSH_PSW,
  input wire logic STK_POP,
  input wire logic POP_PSW,
  input wire logic [7:0] STK_RDATA,
  output logic [15:0] SP_OUT,
  output logic [15:0] STK_ADDR,
  output logic [7:0] STK_WDATA,
  output logic STK_ERR,
  // general registers
  input wire logic GPR_WE,
  input wire logic GPR_PAIR,
  input wire logic [2:0] GPR_IDX,
  input wire logic [15:0] GPR_WDATA,
  output logic [15:0] GPR_RDATA,
  output logic [15:0] GPR_ADDR,
  // special register decode
  input wire logic [15:0] MEM_ADDR,
  input wire logic [1:0] MEM_WIDTH,
  input wire logic DDU_SEL,
  output logic SFR_HIT,
  output logic SFR_ERR
);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, ready and data registered

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic acc;
  logic wr_en;
  logic mapped;
  logic [15:0] pc_q;
  logic [7:0] psw_q;
  logic [15:0] sp_q;
  logic stk_err_q;
  cpr_vec_t vec_q;

  assign acc = PSEL && PENABLE && !pready_q;
  assign wr_en = PSEL && PENABLE && pready_q && PWRITE && !pslverr_q;
  assign mapped = (PADDR == CPR_OFS_PC) || (PADDR == CPR_OFS_PSW)
    || (PADDR == CPR_OFS_SP) || (PADDR == CPR_OFS_STAT);

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc && !mapped;
      if (acc && !PWRITE)
      begin
        case (PADDR)
          CPR_OFS_PC: prdata_q <= {16'h0000, pc_q};
          CPR_OFS_PSW: prdata_q <= {24'h00_0000, psw_q};
          CPR_OFS_SP: prdata_q <= {16'h0000, sp_q};
          CPR_OFS_STAT: prdata_q <= {29'h0000_0000, stk_err_q, vec_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // reset vector fetch and program counter

  logic vec_req_q;
  logic [15:0] vec_addr_q;
  logic [7:0] vec_lo_q;

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      vec_q <= CPR_FETCH_LO;
      vec_req_q <= 1'b0;
      vec_addr_q <= CPR_VEC_LO;
      vec_lo_q <= 8'h00;
    end
    else
    begin
      case (vec_q)
        CPR_FETCH_LO:
        begin
          vec_req_q <= !(vec_req_q && VEC_ACK);
          if (vec_req_q && VEC_ACK)
          begin
            vec_lo_q <= VEC_DATA;
            vec_addr_q <= CPR_VEC_HI;
            vec_q <= CPR_FETCH_HI;
          end
        end
        CPR_FETCH_HI:
        begin
          vec_req_q <= !(vec_req_q && VEC_ACK);
          if (vec_req_q && VEC_ACK)
          begin
            vec_q <= CPR_RUN;
          end
        end
        CPR_RUN: vec_req_q <= 1'b0;
        default: vec_q <= CPR_FETCH_LO;
      endcase
    end
  end

  assign VEC_REQ = vec_req_q;
  assign VEC_ADDR = vec_addr_q;

  logic run_q;

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      run_q <= 1'b0;
    else
      run_q <= (vec_q == CPR_RUN);
  end

  assign CORE_RUN = run_q;

  // core sequencing ignored until the vector is in; core events beat apb writes
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      pc_q <= 16'h0000;
    else if (vec_q == CPR_FETCH_HI && vec_req_q && VEC_ACK)
      pc_q <= {VEC_DATA, vec_lo_q};
    else if (vec_q != CPR_RUN)
      pc_q <= pc_q;
    else if (BRANCH)
      pc_q <= BR_TARGET;
    else if (PC_ADV)
      pc_q <= pc_q + {14'h0000, PC_LEN} + 16'h0001;
    else if (wr_en && PADDR == CPR_OFS_PC)
      pc_q <= PWDATA[15:0];
  end

  assign PC_OUT = pc_q;

  ////////////////////////////////////////////////////////////////////////////
  // program status word

  logic push_psw;
  logic pop_any;
  logic push_any;

  assign push_psw = PUSH_PSW || INT_ACK;
  assign push_any = STK_PUSH || push_psw;
  assign pop_any = STK_POP || POP_PSW;

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      psw_q <= CPR_PSW_RST;
    else if (POP_PSW)
      psw_q <= STK_RDATA;
    else
    begin
      if (wr_en && PADDR == CPR_OFS_PSW)
        psw_q <= PWDATA[7:0] & CPR_PSW_WMASK;
      if (INT_ACK || MASK_ALL)
        psw_q[CPR_B_INTEN] <= 1'b0;
      else if (UNMASK_ALL)
        psw_q[CPR_B_INTEN] <= 1'b1;
      if (ALU_UPD)
      begin
        psw_q[CPR_B_Z] <= (ALU_RES == 8'h00);
        psw_q[CPR_B_HCARRY] <= ALU_HCARRY;
        psw_q[CPR_B_CARRY] <= ALU_CARRY;
      end
      else if (CARRY_WE)
        psw_q[CPR_B_CARRY] <= CARRY_IN;
      if (BANK_SW)
      begin
        psw_q[CPR_B_BANK1] <= BANK_IN[1];
        psw_q[CPR_B_BANK0] <= BANK_IN[0];
      end
      if (INSRV_WE)
        psw_q[CPR_B_INSRV] <= INSRV_IN;
    end
  end

  assign PSW_OUT = psw_q;

  // requests are judged on the flags as they stand this cycle
  logic int_ok_q;

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      int_ok_q <= 1'b0;
    else
      int_ok_q <= INT_REQ && !INT_MASKED && psw_q[CPR_B_INTEN]
        && (!INT_LOW_PRI || psw_q[CPR_B_INSRV]);
  end

  assign INT_OK = int_ok_q;

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer: pre-decrement push, post-increment pop

  logic [15:0] sp_dec;
  logic [15:0] stk_addr_q;
  logic [7:0] stk_wdata_q;
  logic stk_oor;

  assign sp_dec = sp_q - 16'h0001;
  assign stk_oor = push_any ? (sp_dec < CPR_HSRAM_LO || sp_dec > CPR_HSRAM_TOP)
    : (sp_q < CPR_HSRAM_LO || sp_q > CPR_HSRAM_TOP);

  // no reset on purpose: contents are undefined until software loads them
  always_ff @(posedge SYS_CLK)
  begin
    if (push_any)
      sp_q <= sp_dec;
    else if (pop_any)
      sp_q <= sp_q + 16'h0001;
    else if (wr_en && PADDR == CPR_OFS_SP)
      sp_q <= PWDATA[15:0];
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      stk_addr_q <= 16'h0000;
      stk_wdata_q <= 8'h00;
    end
    else if (push_any)
    begin
      stk_addr_q <= sp_dec;
      stk_wdata_q <= push_psw ? psw_q : STK_DIN;
    end
    else if (pop_any)
      stk_addr_q <= sp_q;
  end

  // sticky; a new fault wins over the clearing write of the pointer
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      stk_err_q <= 1'b0;
    else if ((push_any || pop_any) && stk_oor)
      stk_err_q <= 1'b1;
    else if (wr_en && PADDR == CPR_OFS_SP)
      stk_err_q <= 1'b0;
  end

  assign SP_OUT = sp_q;
  assign STK_ADDR = stk_addr_q;
  assign STK_WDATA = stk_wdata_q;
  assign STK_ERR = stk_err_q;

  ////////////////////////////////////////////////////////////////////////////
  // general registers, banked

  logic [7:0] gpr_mem [CPR_BANKS*CPR_BANK_REGS];
  logic [1:0] bank;
  logic [4:0] lo_idx;
  logic [4:0] hi_idx;
  logic [15:0] gpr_rdata_q;
  logic [15:0] gpr_addr_q;

  assign bank = {psw_q[CPR_B_BANK1], psw_q[CPR_B_BANK0]};
  assign lo_idx = {bank, GPR_IDX[2:1], GPR_IDX[0] & !GPR_PAIR};
  assign hi_idx = {bank, GPR_IDX[2:1], 1'b1};

  always_ff @(posedge SYS_CLK)
  begin
    if (GPR_WE)
    begin
      gpr_mem[lo_idx] <= GPR_WDATA[7:0];
      if (GPR_PAIR)
        gpr_mem[hi_idx] <= GPR_WDATA[15:8];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      gpr_rdata_q <= 16'h0000;
      gpr_addr_q <= CPR_GPR_BASE;
    end
    else
    begin
      gpr_rdata_q <= {GPR_PAIR ? gpr_mem[hi_idx] : 8'h00, gpr_mem[lo_idx]};
      gpr_addr_q <= CPR_GPR_BASE + {11'h000, lo_idx};
    end
  end

  assign GPR_RDATA = gpr_rdata_q;
  assign GPR_ADDR = gpr_addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // special register window and width checks

  logic sfr_win;
  logic sfr_hit_q;
  logic sfr_err_q;

  assign sfr_win = DDU_SEL ? (MEM_ADDR <= CPR_DDU_TOP) : (MEM_ADDR >= CPR_SFR_BASE);

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sfr_hit_q <= 1'b0;
      sfr_err_q <= 1'b0;
    end
    else
    begin
      sfr_hit_q <= sfr_win;
      sfr_err_q <= sfr_win && ((MEM_WIDTH == CPR_W_WORD && MEM_ADDR[0])
        || (MEM_WIDTH != CPR_W_BIT && MEM_WIDTH != CPR_W_BYTE
        && MEM_WIDTH != CPR_W_WORD));
    end
  end

  assign SFR_HIT = sfr_hit_q;
  assign SFR_ERR = sfr_err_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_pc_advance: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    run_q && vec_q == CPR_RUN && PC_ADV && !BRANCH
    |=> pc_q == $past(pc_q) + {14'h0000, $past(PC_LEN)} + 16'h0001)
    else $error("pc did not advance by length");

  a_pc_branch: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    vec_q == CPR_RUN && BRANCH |=> pc_q == $past(BR_TARGET))
    else $error("branch target not loaded");

  a_vec_load: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    vec_q == CPR_FETCH_HI && vec_req_q && VEC_ACK
    |=> pc_q == {$past(VEC_DATA), $past(vec_lo_q)} && vec_q == CPR_RUN ##1 run_q)
    else $error("reset vector not loaded");

  a_psw_push: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    push_psw |=> stk_wdata_q == $past(psw_q) && stk_addr_q == sp_q)
    else $error("status word not pushed");

  a_ie_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (MASK_ALL || INT_ACK) && !POP_PSW |=> !psw_q[CPR_B_INTEN])
    else $error("enable flag not cleared");

  a_int_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !psw_q[CPR_B_INTEN] |=> !int_ok_q)
    else $error("request accepted while disabled");

  a_low_pri: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    INT_LOW_PRI && !psw_q[CPR_B_INSRV] |=> !int_ok_q)
    else $error("low priority accepted");

  a_zero_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ALU_UPD && !POP_PSW |=> psw_q[CPR_B_Z] == ($past(ALU_RES) == 8'h00))
    else $error("zero flag wrong");

  a_sp_pop: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    pop_any && !push_any |=> sp_q == $past(sp_q) + 16'h0001)
    else $error("stack pointer not incremented");

  a_sfr_odd: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    sfr_win && MEM_WIDTH == CPR_W_WORD && MEM_ADDR[0] |=> sfr_err_q && sfr_hit_q)
    else $error("odd word access not flagged");

endmodule
`default_nettype wire

// ===== cpr_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module cpr_regs_test
  import cpr_pkg::*;
;
  typedef struct {int sel; int due; logic [15:0] v;} cpr_exp_t;
  localparam int S_PC = 0, S_PSW = 1, S_SP = 2, S_SA = 3, S_WD = 4, S_GA = 5, S_INT = 6;
  localparam int S_ERR = 7, S_HIT = 8, S_VA = 9, S_RD = 10, S_SE = 11;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, vec_req, vec_ack, core_run;
  logic pc_adv, branch, alu_upd, alu_hcarry, alu_carry, carry_we, carry_in;
  logic mask_all, unmask_all, bank_sw;
  logic insrv_we, insrv_in, int_req, int_low_pri, int_masked, int_ack, int_ok, stk_push, push_psw;
  logic stk_pop, pop_psw, stk_err, gpr_we, gpr_pair, ddu_sel, sfr_hit, sfr_err;
  logic [1:0] pc_len, bank_in, mem_width;
  logic [2:0] gpr_idx;
  logic [7:0] vec_data, alu_res, psw_out, stk_din, stk_rdata, stk_wdata, program_status_word, r8;
  logic [11:0] paddr;
  logic [15:0] vec_addr, br_target, pc_out, sp_out, stk_addr, gpr_wdata, gpr_rdata, gpr_addr;
  logic [15:0] mem_addr, pc, sp, act;
  logic [31:0] pwdata, prdata;
  logic [33:0] ae;
  logic [33:0] aq[$];
  cpr_exp_t cq[$];
  cpr_exp_t e;
  int num_errors, checked, cyc;

  cpr_regs cpr_regs_inst (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .VEC_REQ(vec_req), .VEC_ADDR(vec_addr), .VEC_ACK(vec_ack), .VEC_DATA(vec_data),
    .CORE_RUN(core_run), .PC_ADV(pc_adv), .PC_LEN(pc_len), .BRANCH(branch),
    .BR_TARGET(br_target), .PC_OUT(pc_out), .ALU_UPD(alu_upd), .ALU_RES(alu_res),
    .ALU_HCARRY(alu_hcarry), .ALU_CARRY(alu_carry), .CARRY_WE(carry_we),
    .CARRY_IN(carry_in), .MASK_ALL(mask_all), .UNMASK_ALL(unmask_all), .BANK_SW(bank_sw),
    .BANK_IN(bank_in), .INSRV_WE(insrv_we), .INSRV_IN(insrv_in), .PSW_OUT(psw_out),
    .INT_REQ(int_req), .INT_LOW_PRI(int_low_pri),
    .INT_MASKED(int_masked), .INT_ACK(int_ack), .INT_OK(int_ok), .STK_PUSH(stk_push),
    .STK_DIN(stk_din), .PUSH_PSW(push_psw), .STK_POP(stk_pop), .POP_PSW(pop_psw),
    .STK_RDATA(stk_rdata), .SP_OUT(sp_out), .STK_ADDR(stk_addr), .STK_WDATA(stk_wdata),
    .STK_ERR(stk_err), .GPR_WE(gpr_we), .GPR_PAIR(gpr_pair), .GPR_IDX(gpr_idx),
    .GPR_WDATA(gpr_wdata), .GPR_RDATA(gpr_rdata), .GPR_ADDR(gpr_addr), .MEM_ADDR(mem_addr),
    .MEM_WIDTH(mem_width), .DDU_SEL(ddu_sel), .SFR_HIT(sfr_hit), .SFR_ERR(sfr_err)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic step;
    @(posedge sys_clk);
  endtask
  // bounded wait, never trusts a fixed latency
  task automatic waitfor(ref logic s);
    int n;
    n = 0;
    do
    begin
      step;
      n++;
    end
    while (s !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      num_errors++;
      $display("mismatch at %0t: wait timed out", $time);
    end
  endtask
  // note falls due one edge later, when the registered output has settled
  task automatic chk(input int sel, input logic [15:0] v);
    cq.push_back('{sel, cyc + 1, v});
    step;
  endtask
  task automatic done(input string s);
    $display("test %s finished at %0t", s, $time);
  endtask
  task automatic cmp_core(input int sel, input logic [15:0] a, input logic [15:0] x);
    checked++;
    if (a !== x)
    begin
      num_errors++;
      $display("mismatch at %0t: item %0d got %h expected %h", $time, sel, a, x);
    end
  endtask
  task automatic cmp_apb(input logic rd, input logic er, input logic [31:0] d);
    checked++;
    if (pslverr !== er || (rd && prdata !== d))
    begin
      num_errors++;
      $display("mismatch at %0t: apb got %b %h expected %b %h", $time, pslverr, prdata, er, d);
    end
  endtask
  task automatic summarize;
    if (cq.size() > 0 || aq.size() > 0) num_errors++;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er);
    aq.push_back({~w, er, d});
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    step;
    penable <= 1;
    waitfor(pready);
    psel <= 0;
    penable <= 0;
    step;
  endtask
  task automatic vec(input logic [15:0] a, input logic [7:0] d);
    waitfor(vec_req);
    vec_ack <= 1;
    vec_data <= d;
    chk(S_VA, a);
    vec_ack <= 0;
  endtask
  task automatic alu(input logic [7:0] r, input logic hc, input logic co, input logic [7:0] x);
    alu_upd <= 1;
    alu_res <= r;
    alu_hcarry <= hc;
    alu_carry <= co;
    step;
    alu_upd <= 0;
    chk(S_PSW, {8'h00, x});
  endtask
  task automatic ichk(input logic lp, input logic m, input logic x);
    int_low_pri <= lp;
    int_masked <= m;
    step;
    chk(S_INT, {15'h0000, x});
  endtask
  task automatic stk(input logic ps, input logic [7:0] d);
    push_psw <= ps;
    stk_push <= !ps;
    stk_din <= d;
    step;
    push_psw <= 0;
    stk_push <= 0;
    sp = sp - 16'h0001;
    chk(S_SP, sp);
    chk(S_SA, sp);
    chk(S_WD, {8'h00, ps ? program_status_word : d});
  endtask
  task automatic sfr(input logic [15:0] a, input logic [1:0] w, input logic d, input logic h,
                     input logic er);
    mem_addr <= a;
    mem_width <= w;
    ddu_sel <= d;
    step;
    chk(S_ERR, {15'h0000, er});
    if (!er) chk(S_HIT, {15'h0000, h});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cq.size() > 0 && cq[0].due == cyc)
    begin
      e = cq.pop_front();
      case (e.sel)
        S_PC: act = pc_out;
        S_PSW: act = {8'h00, psw_out};
        S_SP: act = sp_out;
        S_SA: act = stk_addr;
        S_WD: act = {8'h00, stk_wdata};
        S_GA: act = gpr_addr;
        S_INT: act = {15'h0000, int_ok};
        S_ERR: act = {15'h0000, sfr_err};
        S_HIT: act = {15'h0000, sfr_hit};
        S_VA: act = vec_addr;
        S_SE: act = {15'h0000, stk_err};
        default: act = gpr_rdata;
      endcase
      cmp_core(e.sel, act, e.v);
    end
    if (psel && penable && pready === 1'b1)
    begin
      ae = aq.pop_front();
      cmp_apb(ae[33], ae[32], ae[31:0]);
    end
  end

  initial
  begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  // a few hundred cycles are expected; this is far beyond that
  initial
  begin
    #100000;
    $display("mismatch at %0t: watchdog expired", $time);
    num_errors++;
    summarize;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, psel, penable, pwrite, vec_ack, pc_adv, branch, alu_upd, alu_hcarry, alu_carry} = '0;
    {carry_we, carry_in, mask_all, unmask_all, bank_sw, insrv_we, insrv_in, int_req} = '0;
    {int_low_pri, int_masked} = '0;
    {int_ack, stk_push, push_psw, stk_pop, pop_psw, gpr_we, gpr_pair, ddu_sel, pc_len} = '0;
    {bank_in, mem_width, gpr_idx, vec_data, alu_res, stk_din, stk_rdata, paddr, pwdata} = '0;
    {br_target, gpr_wdata, mem_addr} = '0;
    r8 = 8'($urandom(32'hb2662dc5));
    repeat (16) step;
    rst_n <= 1;
    chk(S_PSW, 16'h0002);
    pc = 16'($urandom);
    vec(CPR_VEC_LO, pc[7:0]);
    vec(CPR_VEC_HI, pc[15:8]);
    waitfor(core_run);
    chk(S_PC, pc);
    done("vector");
    for (int l = 0; l < 4; l++)
    begin
      pc_adv <= 1;
      pc_len <= 2'(l);
      step;
      pc_adv <= 0;
      pc = pc + 16'(l + 1);
      chk(S_PC, pc);
    end
    // branch raised together with advance: the load must win
    pc = 16'($urandom);
    br_target <= pc;
    branch <= 1;
    pc_adv <= 1;
    step;
    branch <= 0;
    pc_adv <= 0;
    chk(S_PC, pc);
    done("sequencing");
    pc = 16'($urandom);
    apb(1, CPR_OFS_PC, {16'h0000, pc}, 0);
    apb(0, CPR_OFS_PC, {16'h0000, pc}, 0);
    apb(0, CPR_OFS_PSW, 32'h0000_0002, 0);
    apb(0, 12'h010, 32'h0000_0000, 1);
    sp = 16'hfe00;
    apb(1, CPR_OFS_SP, {16'h0000, sp}, 0);
    apb(0, CPR_OFS_SP, {16'h0000, sp}, 0);
    apb(1, CPR_OFS_PSW, 32'h0000_00ff, 0);
    apb(0, CPR_OFS_PSW, 32'h0000_00fb, 0);
    apb(1, CPR_OFS_PSW, 32'h0000_0002, 0);
    done("registers");
    alu(8'h00, 1, 1, 8'h53);
    alu(8'($urandom_range(255, 1)), 0, 0, 8'h02);
    alu(8'h01, 1, 0, 8'h12);
    carry_we <= 1;
    carry_in <= 1;
    step;
    carry_we <= 0;
    chk(S_PSW, 16'h0013);
    unmask_all <= 1;
    step;
    unmask_all <= 0;
    chk(S_PSW, 16'h0093);
    mask_all <= 1;
    unmask_all <= 1;
    step;
    mask_all <= 0;
    unmask_all <= 0;
    chk(S_PSW, 16'h0013);
    program_status_word = 8'h13;
    for (int b = 0; b < 4; b++)
    begin
      r8 = 8'($urandom);
      bank_sw <= 1;
      bank_in <= 2'(b);
      step;
      bank_sw <= 0;
      gpr_idx <= r8[2:0];
      program_status_word[5] = b[1];
      program_status_word[3] = b[0];
      chk(S_PSW, {8'h00, program_status_word});
      chk(S_GA, CPR_GPR_BASE + 16'(8 * b) + 16'(r8[2:0]));
    end
    pc = 16'($urandom);
    gpr_we <= 1;
    gpr_idx <= 3'h2;
    gpr_wdata <= {8'h00, pc[7:0]};
    step;
    gpr_idx <= 3'h3;
    gpr_wdata <= {8'h00, pc[15:8]};
    step;
    gpr_we <= 0;
    gpr_pair <= 1;
    gpr_idx <= 3'h2;
    step;
    chk(S_RD, pc);
    chk(S_GA, 16'hfefa);
    done("flags and banks");
    int_req <= 1;
    ichk(0, 0, 0);
    unmask_all <= 1;
    step;
    unmask_all <= 0;
    ichk(0, 0, 1);
    ichk(0, 1, 0);
    insrv_we <= 1;
    insrv_in <= 0;
    step;
    insrv_we <= 0;
    ichk(1, 0, 0);
    ichk(0, 0, 1);
    int_ack <= 1;
    step;
    int_ack <= 0;
    int_req <= 0;
    program_status_word = 8'h39;
    sp = sp - 16'h0001;
    chk(S_PSW, {8'h00, program_status_word});
    chk(S_SP, sp);
    stk(1, 8'h00);
    stk(0, 8'($urandom));
    r8 = 8'($urandom) & 8'hfb;
    stk_pop <= 1;
    pop_psw <= 1;
    stk_rdata <= r8;
    step;
    stk_pop <= 0;
    pop_psw <= 0;
    chk(S_SA, sp);
    chk(S_SP, sp + 16'h0001);
    chk(S_PSW, {8'h00, r8});
    // a push below the bottom of high-speed ram must raise the sticky error
    sp = CPR_HSRAM_LO;
    apb(1, CPR_OFS_SP, {16'h0000, sp}, 0);
    stk(0, 8'($urandom));
    chk(S_SE, 16'h0001);
    apb(0, CPR_OFS_STAT, 32'h0000_0006, 0);
    sp = 16'hfe00;
    apb(1, CPR_OFS_SP, {16'h0000, sp}, 0);
    chk(S_SE, 16'h0000);
    done("interrupts and stack");
    r8 = 8'($urandom);
    sfr({8'hff, r8}, CPR_W_BYTE, 0, 1, 0);
    sfr(16'hffff, CPR_W_BIT, 0, 1, 0);
    sfr({8'hff, r8[7:1], 1'b0}, CPR_W_WORD, 0, 1, 0);
    sfr(16'hff13, CPR_W_WORD, 0, 1, 1);
    sfr(16'hfeff, CPR_W_BYTE, 0, 0, 0);
    sfr(CPR_DDU_TOP, CPR_W_BYTE, 1, 1, 0);
    sfr(16'hff01, 2'h3, 0, 1, 1);
    done("decode");
    step;
    summarize;
  end
endmodule
`default_nettype wire
